/* iopfm_cfg.svh */
/*
 iopfm_cfg.svh: register offsets, field positions, reset values and timing counts
 for the I/O polarity and fan mapper. Included by the package; the top module uses its macros.
*/
`ifndef IOPFM_CFG_SVH
`define IOPFM_CFG_SVH

// register byte offsets (APB, one aligned word each)
`define IOPFM_OFF_POL 12'h000
`define IOPFM_OFF_FAN 12'h004
`define IOPFM_OFF_FANTIME 12'h008
`define IOPFM_OFF_BAUD 12'h00C
`define IOPFM_OFF_CTRL 12'h010
`define IOPFM_OFF_STATUS 12'h014

// polarity register fields
`define IOPFM_POL_CARRIER 0
`define IOPFM_POL_ALTSEL 1
`define IOPFM_POL_TXKEY 2
`define IOPFM_POL_MORSE 3
`define IOPFM_POL_BEACON 4
`define IOPFM_POL_IDENT 5
`define IOPFM_POL_RESET 6'h00

// fan select codes
`define IOPFM_FAN_NONE 2'h0
`define IOPFM_FAN_BEACON 2'h1
`define IOPFM_FAN_MORSE 2'h2
`define IOPFM_FAN_IDENT 2'h3

// control register fields (software-driven indications)
`define IOPFM_CTL_TXKEY 0
`define IOPFM_CTL_MORSE 1
`define IOPFM_CTL_BEACON 2
`define IOPFM_CTL_IDENT 3

// reset values
`define IOPFM_FANTIME_RESET 16'h001E
`define IOPFM_BAUD_RESET 32'h00002580

// one second of system clock at 100 MHz
`define IOPFM_CLK_HZ 100000000
`define IOPFM_SEC_CYCLES (`IOPFM_CLK_HZ)

`endif

/* iopfm_chk.sv */
/* iopfm_chk.sv: assertions on the ports of iopfm_top.
 Assumes CLK_EN_I stays high and writes use all byte lanes. */
`timescale 1ns/10ps
`default_nettype none
module iopfm_chk #(
	parameter int SEC_CYCLES = 10
) (
	// clock, reset, apb
	input wire logic SYS_CLK_I, RESETN_I, PSEL_I, PENABLE_I, PWRITE_I,
	input wire logic [11:0] PADDR_I,
	input wire logic [31:0] PWDATA_I,
	// pins, requests, conditioned levels
	input wire logic CARRIER_DETECT_INPUT_I, ALTERNATE_MESSAGE_SELECT_I,
	input wire logic TX_KEY_REQ_I, MORSE_ELEMENT_I, BEACON_ACTIVE_I, IDENT_ACTIVE_I,
	input wire logic CARRIER_ACTIVE_O, ALT_MESSAGE_ACTIVE_O,
	input wire logic TRANSMIT_KEY_OUTPUT_OE_O, MORSE_KEYING_OUTPUT_OE_O,
	input wire logic BEACON_INDICATOR_OE_O, IDENTIFY_INDICATOR_OE_O
);
	logic [5:0] pol;
	logic [1:0] fan, up;
	logic [3:0] ctl;
	logic wr, fpin;
	assign wr = PSEL_I && PENABLE_I && PWRITE_I;
	assign fpin = fan[1] ? (fan[0] ? IDENTIFY_INDICATOR_OE_O : MORSE_KEYING_OUTPUT_OE_O)
		: BEACON_INDICATOR_OE_O;
	// shadow settings; up masks the edges whose history still holds reset values
	always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			{pol, fan, up} <= 10'h000;
			ctl <= 4'h0;
		end else begin
			if (wr && PADDR_I == 12'h010) ctl <= PWDATA_I[3:0];
			up <= up + {1'h0, up != 2'h3};
			if (wr && PADDR_I == 12'h000) pol <= PWDATA_I[5:0];
			if (wr && PADDR_I == 12'h004) fan <= PWDATA_I[1:0];
		end
	end
	default clocking @(posedge SYS_CLK_I); endclocking
	default disable iff (!RESETN_I);
	carrier_sync_a: assert property (up == 2'h3 |-> CARRIER_ACTIVE_O ==
		($past(CARRIER_DETECT_INPUT_I, 2) ~^ pol[0])) else $error("carrier level wrong");
	alt_sync_a: assert property (up == 2'h3 |-> ALT_MESSAGE_ACTIVE_O ==
		($past(ALTERNATE_MESSAGE_SELECT_I, 2) ~^ pol[1])) else $error("alt level wrong");
	key_out_a: assert property (up != 2'h0 |-> TRANSMIT_KEY_OUTPUT_OE_O ==
		$past((TX_KEY_REQ_I | ctl[0]) ~^ pol[2])) else $error("key pin wrong");
	morse_out_a: assert property (up != 2'h0 && $past(fan) != 2'h2 |->
		MORSE_KEYING_OUTPUT_OE_O == $past((MORSE_ELEMENT_I | ctl[1]) ~^ pol[3]))
		else $error("morse pin");
	beacon_out_a: assert property (up != 2'h0 && $past(fan) != 2'h1 |->
		BEACON_INDICATOR_OE_O == $past((BEACON_ACTIVE_I | ctl[2]) ~^ pol[4]))
		else $error("beacon pin");
	ident_out_a: assert property (up != 2'h0 && $past(fan) != 2'h3 |->
		IDENTIFY_INDICATOR_OE_O == $past((IDENT_ACTIVE_I | ctl[3]) ~^ pol[5]))
		else $error("ident pin");
	fan_ground_a: assert property (fan != 2'h0 && $stable(fan) && CARRIER_ACTIVE_O
		|=> !fpin) else $error("fan not grounded");
	fan_hold_a: assert property (fan != 2'h0 && $fell(CARRIER_ACTIVE_O)
		|=> !fpin [*8]) else $error("fan released early");
endmodule
bind iopfm_top iopfm_chk #(.SEC_CYCLES(SEC_CYCLES)) chk_i (.*);
`default_nettype wire

/* iopfm_pkg.sv */
/*
 iopfm_pkg.sv: types shared by the I/O polarity and fan mapper.
 Assumes iopfm_cfg.svh is on the include path.
*/
`include "iopfm_cfg.svh"
package iopfm_pkg;
	typedef logic [1:0] iopfm_fan_sel_t;
	typedef enum logic [1:0] {
		FAN_IDLE,
		FAN_CARRIER,
		FAN_HOLD
	} iopfm_fan_state_t;
endpackage

/* iopfm_radio.sv */
/* iopfm_radio.sv: radio side of the pins.
 Assumes open-drain pins have pull-ups at the radio. */
`timescale 1ns/10ps
`default_nettype none
module iopfm_radio (
	// intent and wiring sense, 1 = high active
	input wire logic car_on_i, alt_on_i,
	input wire logic [1:0] high_i,
	input wire logic [3:0] oe_i,
	// raw pins into the controller, pin levels seen here
	output logic car_pin_o, alt_pin_o,
	output logic [3:0] level_o
);
	assign car_pin_o = car_on_i ~^ high_i[0];
	assign alt_pin_o = alt_on_i ~^ high_i[1];
	// released pins rise through the pull-up, so the level never floats
	assign level_o = oe_i;
endmodule
`default_nettype wire

/* iopfm_tb_top.sv */
/* iopfm_tb_top.sv: self-checking bench for iopfm_top.
 Assumes a second lasts 10 cycles via SEC_CYCLES. */
`timescale 1ns/10ps
`default_nettype none
module iopfm_tb_top;
	import iopfm_pkg::*;
	typedef struct {logic [5:0] pol; logic [3:0] req; logic con; logic aon; logic [3:0] pins;}
		iopfm_row_t;
	iopfm_row_t rows [5] = '{'{6'h00, 4'h0, 1'h0, 1'h1, 4'hF}, '{6'h00, 4'hF, 1'h1, 1'h0, 4'h0},
		'{6'h3F, 4'h0, 1'h1, 1'h1, 4'h0}, '{6'h3F, 4'hA, 1'h0, 1'h0, 4'hA},
		'{6'h14, 4'hC, 1'h1, 1'h0, 4'h9}};
	logic clk, rst_n, psel, pen, pwr, perr, rerr, pready, con, aon, car, alt, cact, aact;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdat, baud;
	logic [3:0] req, lvl;
	wire logic [3:0] oe;
	wire logic [3:0] dat;
	logic [1:0] hi;
	int fails, cmp_count, cyc, k, idx;
	iopfm_top #(.SEC_CYCLES(10)) dut (.SYS_CLK_I(clk), .RESETN_I(rst_n), .CLK_EN_I(1'h1),
		.PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata),
		.PSTRB_I(4'hF), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(perr),
		.CARRIER_DETECT_INPUT_I(car), .ALTERNATE_MESSAGE_SELECT_I(alt),
		.TX_KEY_REQ_I(req[3]), .MORSE_ELEMENT_I(req[2]), .BEACON_ACTIVE_I(req[1]),
		.IDENT_ACTIVE_I(req[0]), .CARRIER_ACTIVE_O(cact), .ALT_MESSAGE_ACTIVE_O(aact),
		.TRANSMIT_KEY_OUTPUT_O(dat[3]), .TRANSMIT_KEY_OUTPUT_OE_O(oe[3]),
		.MORSE_KEYING_OUTPUT_O(dat[2]), .MORSE_KEYING_OUTPUT_OE_O(oe[2]),
		.BEACON_INDICATOR_O(dat[1]), .BEACON_INDICATOR_OE_O(oe[1]),
		.IDENTIFY_INDICATOR_O(dat[0]), .IDENTIFY_INDICATOR_OE_O(oe[0]), .GPS_BAUD_O(baud));
	iopfm_radio radio (.car_on_i(con), .alt_on_i(aon), .high_i(hi), .oe_i(oe),
		.car_pin_o(car), .alt_pin_o(alt), .level_o(lvl));
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		cmp_count++;
		if (s !== e) begin
			fails++;
			$display("MISMATCH %s exp %h seen %h", n, e, s);
		end
	endtask
	// the idle edge first keeps two transfers from touching psel in one step
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'h1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'h1;
		do @(posedge clk); while (pready !== 1'h1);
		rdat = prdata;
		rerr = perr;
		psel <= 1'h0;
		pen <= 1'h0;
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	initial begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 8000) begin
			fails++;
			report_and_stop();
		end
	end
	initial begin
		{rst_n, psel, pen, pwr, con, aon, hi, req, paddr, pwdata} = 56'h0;
		repeat (2) @(posedge clk);
		rst_n <= 1'h1;
		for (k = 0; k < 4; k++) begin
			apb(1'h0, 12'(k << 2), 32'h0);
			chk("reset value", k == 2 ? 32'h1E : k == 3 ? 32'h2580 : 32'h0, rdat);
		end
		apb(1'h1, 12'h00C, 32'h12C0);
		apb(1'h0, 12'h00C, 32'h0);
		chk("baud", 32'h12C0, rdat);
		chk("baud pin", 32'h12C0, baud);
		apb(1'h0, 12'h020, 32'h0);
		chk("unmapped", 32'h1, {rdat[30:0], rerr});
		$display("test registers done");
		foreach (rows[i]) begin
			hi <= rows[i].pol[1:0];
			apb(1'h1, 12'h000, {26'h0, rows[i].pol});
			{req, con, aon} <= {rows[i].req, rows[i].con, rows[i].aon};
			repeat (4) @(posedge clk);
			chk("pins", {28'h0, rows[i].pins}, {28'h0, lvl});
			chk("inputs", {30'h0, rows[i].con, rows[i].aon}, {30'h0, cact, aact});
		end
		$display("test rows done");
		hi <= 2'h0;
		apb(1'h1, 12'h000, 32'h0);
		{req, con, aon} <= 6'h00;
		apb(1'h1, 12'h010, 32'hF);
		repeat (2) @(posedge clk);
		chk("ctrl force", 32'h0, {28'h0, lvl});
		chk("pin data", 32'h0, {28'h0, dat});
		apb(1'h0, 12'h014, 32'h0);
		chk("status", 32'h40, {24'h0, rdat[7:0]});
		apb(1'h1, 12'h010, 32'h0);
		$display("test ctrl done");
		{req, con, aon} <= 6'h1C;
		for (k = 1; k < 4; k++) begin
			idx = k == 1 ? 1 : k == 2 ? 2 : 0;
			apb(1'h1, 12'h004, 32'(k));
			repeat (340) @(posedge clk);
			chk("fan idle", 32'h8 | (32'h1 << idx), {28'h0, lvl});
			con <= 1'h1;
			repeat (4) @(posedge clk);
			chk("fan on", 32'h0, {31'h0, lvl[idx]});
			con <= 1'h0;
			repeat (100) @(posedge clk);
			chk("fan hold", 32'h0, {31'h0, lvl[idx]});
			req <= 4'hF;
			@(posedge clk);
			req <= 4'h7;
			repeat (250) @(posedge clk);
			chk("fan restart", 32'h0, {31'h0, lvl[idx]});
			repeat (100) @(posedge clk);
			chk("fan expired", 32'h1, {31'h0, lvl[idx]});
		end
		$display("test fan done");
		apb(1'h1, 12'h000, 32'h3F);
		req <= 4'h0;
		repeat (3) @(posedge clk);
		rst_n <= 1'h0;
		@(negedge clk);
		chk("reset pins", 32'hF, {28'h0, lvl});
		chk("reset baud", 32'h2580, baud);
		@(posedge clk);
		rst_n <= 1'h1;
		apb(1'h0, 12'h000, 32'h0);
		chk("reset pol", 32'h0, rdat);
		$display("test reset done");
		report_and_stop();
	end
endmodule
`default_nettype wire

/* iopfm_top.sv */
/*
 iopfm_top.sv: input polarity, open-drain output polarity, fan routing and
 GPS rate setting of a repeater identify controller, with an APB register slave.
 Assumes one 100 MHz clock; pins come from outside and are synchronised here;
 keying and indication requests come from the controller logic on the same clock
 or from the control register.
*/
`timescale 1ns/10ps
`default_nettype none

// How it works
// - input polarity bit: 0 low active, 1 high
// - output polarity bit: 0 active low, 1 high
// - active low grounds when active, else released
// - fan select routes fan to beacon, morse, identify
// - fan-owned output loses its normal function
// - fan grounds on carrier, holds until timer expires
// - GPS serial rate register, default 9600
// - ground on reset pin resets device
// - beacon indicator active during whole beacon
// - identify indicator active during whole identification
// - morse output is keyed level, not tone
// - fan seconds count after key drops, restart
module iopfm_top
	import iopfm_pkg::*;
#(
	parameter int SEC_CYCLES = `IOPFM_SEC_CYCLES
) (
	// clock, reset, enable
	input wire logic SYS_CLK_I,
	input wire logic RESETN_I,
	input wire logic CLK_EN_I,
	// apb slave
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [11:0] PADDR_I,
	input wire logic [31:0] PWDATA_I,
	input wire logic [3:0] PSTRB_I,
	output logic [31:0] PRDATA_O,
	output logic PREADY_O,
	output logic PSLVERR_O,
	// raw input pins
	input wire logic CARRIER_DETECT_INPUT_I,
	input wire logic ALTERNATE_MESSAGE_SELECT_I,
	// requests from the controller logic
	input wire logic TX_KEY_REQ_I,
	input wire logic MORSE_ELEMENT_I,
	input wire logic BEACON_ACTIVE_I,
	input wire logic IDENT_ACTIVE_I,
	// conditioned inputs for the controller logic
	output logic CARRIER_ACTIVE_O,
	output logic ALT_MESSAGE_ACTIVE_O,
	// open-drain outputs: _o is always low, oe low means pin pulled to ground
	output logic TRANSMIT_KEY_OUTPUT_O,
	output logic TRANSMIT_KEY_OUTPUT_OE_O,
	output logic MORSE_KEYING_OUTPUT_O,
	output logic MORSE_KEYING_OUTPUT_OE_O,
	output logic BEACON_INDICATOR_O,
	output logic BEACON_INDICATOR_OE_O,
	output logic IDENTIFY_INDICATOR_O,
	output logic IDENTIFY_INDICATOR_OE_O,
	// settings for the GPS receiver serial port
	output logic [31:0] GPS_BAUD_O
);
	import iopfm_pkg::*;

	logic [5:0] pol;
	iopfm_fan_sel_t fan_sel;
	logic [15:0] fan_time;
	logic [31:0] baud;
	logic [3:0] ctrl;
	logic [1:0] carrier_sync;
	logic [1:0] alt_sync;
	logic carrier_act;
	logic alt_act;
	logic key_act;
	logic morse_act;
	logic beacon_act;
	logic ident_act;
	logic fan_on;
	iopfm_fan_state_t fan_state;
	logic [31:0] sec_cnt;
	logic [15:0] sec_left;
	logic apb_wr;
	logic apb_rd;
	logic addr_ok;
	logic [3:0] key_drv;
	logic [31:0] next_rdata;

	function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] strb);
		logic [31:0] r;
		r = old_v;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				r[b*8 +: 8] = new_v[b*8 +: 8];
			end
		end
		return r;
	endfunction

	// true when the pin should be released (oe high): active-low releases when idle
	function automatic logic release_pin(input logic active, input logic pol_bit);
		return active ~^ pol_bit;
	endfunction

	// apb: zero wait state, every access completes in its access phase
	assign PREADY_O = 1'b1;
	assign addr_ok = (PADDR_I == `IOPFM_OFF_POL) || (PADDR_I == `IOPFM_OFF_FAN) ||
		(PADDR_I == `IOPFM_OFF_FANTIME) || (PADDR_I == `IOPFM_OFF_BAUD) ||
		(PADDR_I == `IOPFM_OFF_CTRL) || (PADDR_I == `IOPFM_OFF_STATUS);
	assign PSLVERR_O = PSEL_I && PENABLE_I && !addr_ok;
	assign apb_wr = PSEL_I && PENABLE_I && PWRITE_I && addr_ok && CLK_EN_I;
	assign apb_rd = PSEL_I && !PENABLE_I && !PWRITE_I && CLK_EN_I;

	// all registers reset from the external reset pin, asynchronously
	always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			pol <= `IOPFM_POL_RESET;
			fan_sel <= `IOPFM_FAN_NONE;
			fan_time <= `IOPFM_FANTIME_RESET;
			baud <= `IOPFM_BAUD_RESET;
			ctrl <= 4'h0;
		end else if (apb_wr) begin
			case (PADDR_I)
				`IOPFM_OFF_POL: begin
					pol <= 6'(merge_bytes({26'h0, pol}, PWDATA_I, PSTRB_I));
				end
				`IOPFM_OFF_FAN: begin
					fan_sel <= 2'(merge_bytes({30'h0, fan_sel}, PWDATA_I, PSTRB_I));
				end
				`IOPFM_OFF_FANTIME: begin
					fan_time <= 16'(merge_bytes({16'h0, fan_time}, PWDATA_I, PSTRB_I));
				end
				`IOPFM_OFF_BAUD: begin
					baud <= merge_bytes(baud, PWDATA_I, PSTRB_I);
				end
				`IOPFM_OFF_CTRL: begin
					ctrl <= 4'(merge_bytes({28'h0, ctrl}, PWDATA_I, PSTRB_I));
				end
				default: begin
				end
			endcase
		end
	end

	always_comb begin
		case (PADDR_I)
			`IOPFM_OFF_POL: next_rdata = {26'h0, pol};
			`IOPFM_OFF_FAN: next_rdata = {30'h0, fan_sel};
			`IOPFM_OFF_FANTIME: next_rdata = {16'h0, fan_time};
			`IOPFM_OFF_BAUD: next_rdata = baud;
			`IOPFM_OFF_CTRL: next_rdata = {28'h0, ctrl};
			`IOPFM_OFF_STATUS: next_rdata = {sec_left, 8'h0, 1'b0, fan_on, 1'b0,
				fan_state == FAN_HOLD, 2'h0, alt_act, carrier_act};
			default: next_rdata = 32'h0;
		endcase
	end

	// read data registered in the setup phase, stable through the access phase
	always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			PRDATA_O <= 32'h0;
		end else if (apb_rd) begin
			PRDATA_O <= next_rdata;
		end
	end

	// first stage feeds only the second; polarity is applied after the pair
	always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			carrier_sync <= 2'h0;
			alt_sync <= 2'h0;
		end else if (CLK_EN_I) begin
			carrier_sync <= {carrier_sync[0], CARRIER_DETECT_INPUT_I};
			alt_sync <= {alt_sync[0], ALTERNATE_MESSAGE_SELECT_I};
		end
	end

	assign carrier_act = carrier_sync[1] ~^ pol[`IOPFM_POL_CARRIER];
	assign alt_act = alt_sync[1] ~^ pol[`IOPFM_POL_ALTSEL];
	assign CARRIER_ACTIVE_O = carrier_act;
	assign ALT_MESSAGE_ACTIVE_O = alt_act;

	assign key_act = TX_KEY_REQ_I | ctrl[`IOPFM_CTL_TXKEY];
	assign morse_act = MORSE_ELEMENT_I | ctrl[`IOPFM_CTL_MORSE];
	assign beacon_act = BEACON_ACTIVE_I | ctrl[`IOPFM_CTL_BEACON];
	assign ident_act = IDENT_ACTIVE_I | ctrl[`IOPFM_CTL_IDENT];

	// fan: on with carrier or key, hold counts whole seconds after both drop
	always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			fan_state <= FAN_IDLE;
			sec_cnt <= 32'h0;
			sec_left <= 16'h0;
		end else if (CLK_EN_I) begin
			case (fan_state)
				FAN_IDLE: begin
					if (carrier_act || key_act) begin
						fan_state <= FAN_CARRIER;
					end
				end
				FAN_CARRIER: begin
					if (!carrier_act && !key_act) begin
						sec_cnt <= 32'h0;
						sec_left <= fan_time;
						fan_state <= (fan_time == 16'h0) ? FAN_IDLE : FAN_HOLD;
					end
				end
				FAN_HOLD: begin
					if (carrier_act || key_act) begin
						fan_state <= FAN_CARRIER;
					end else if (sec_cnt == 32'(SEC_CYCLES - 1)) begin
						sec_cnt <= 32'h0;
						sec_left <= sec_left - 16'h1;
						if (sec_left == 16'h1) begin
							fan_state <= FAN_IDLE;
						end
					end else begin
						sec_cnt <= sec_cnt + 32'h1;
					end
				end
				default: begin
					fan_state <= FAN_IDLE;
				end
			endcase
		end
	end

	assign fan_on = (fan_state != FAN_IDLE) || carrier_act;

	// fan grounds its pin when on, regardless of polarity setting
	always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			key_drv <= 4'hF;
		end else if (CLK_EN_I) begin
			key_drv[0] <= release_pin(key_act, pol[`IOPFM_POL_TXKEY]);
			key_drv[1] <= (fan_sel == `IOPFM_FAN_MORSE) ? !fan_on :
				release_pin(morse_act, pol[`IOPFM_POL_MORSE]);
			key_drv[2] <= (fan_sel == `IOPFM_FAN_BEACON) ? !fan_on :
				release_pin(beacon_act, pol[`IOPFM_POL_BEACON]);
			key_drv[3] <= (fan_sel == `IOPFM_FAN_IDENT) ? !fan_on :
				release_pin(ident_act, pol[`IOPFM_POL_IDENT]);
		end
	end

	assign TRANSMIT_KEY_OUTPUT_O = 1'b0;
	assign MORSE_KEYING_OUTPUT_O = 1'b0;
	assign BEACON_INDICATOR_O = 1'b0;
	assign IDENTIFY_INDICATOR_O = 1'b0;
	assign TRANSMIT_KEY_OUTPUT_OE_O = key_drv[0];
	assign MORSE_KEYING_OUTPUT_OE_O = key_drv[1];
	assign BEACON_INDICATOR_OE_O = key_drv[2];
	assign IDENTIFY_INDICATOR_OE_O = key_drv[3];
	assign GPS_BAUD_O = baud;
endmodule

`default_nettype wire
